// >>> logic/php_bus_if.sv
// Pin bundle between host and device ends
`timescale 1ns/1ps
interface php_bus_if;
  logic [9:0] addr;
  logic cs_n;
  logic rd_ds_n;
  logic wr_rw_n;
  logic rst_n;
  logic [7:0] data_host_o;
  logic data_host_oe;
  logic [7:0] data_dev_o;
  logic [7:0] data_dev_oe;
  logic [7:0] data_in;
  logic scan_mode;
  // Undriven bits show the inverse of the device's current data output
  assign data_in = data_host_oe ? data_host_o : ~(data_dev_o ^ data_dev_oe);
  modport device (
    input addr, cs_n, rd_ds_n, wr_rw_n, rst_n, data_in, scan_mode,
    output data_dev_o, data_dev_oe
  );
  modport host (
    output addr, cs_n, rd_ds_n, wr_rw_n, rst_n, data_host_o, data_host_oe,
    input data_in
  );
endinterface

// >>> logic/php_defs.svh
// Constants of the parallel host register port
`ifndef PHP_DEFS_SVH
`define PHP_DEFS_SVH
`define PHP_ADDR_W 10
`define PHP_DATA_W 8
`define PHP_NUM_REGS 1024
`define PHP_REG_RST 8'h00
`define PHP_HOST_SETUP 4'h3
`define PHP_HOST_STROBE 4'h4
`define PHP_HOST_HOLD 4'h2
`endif

// >>> logic/php_device.sv
// Device end: register file behind the parallel host port
// Notes on behaviour
// - Ten address bits, bit zero least significant
// - Eight bit bidirectional data, bit zero least
// - Data bus released when deselected or reset, except in scan mode
// - Pair mode: write on write strobe rise
// - Host keeps select low through writes
// - Pair mode: drive data while read, select low
// - Direction line high reads, low writes
// - Data strobe low qualifies reads and writes
// - Scan mode drives every data pin with scan data
// - Strobes ignored while select is high
`timescale 1ns/1ps
`include "php_defs.svh"
module php_device #(
  parameter int ADDR_W = `PHP_ADDR_W,
  parameter int DATA_W = `PHP_DATA_W
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // Configuration
  input wire php_pkg::php_mode_type bus_mode,
  // Scan observe and drive
  input wire logic [DATA_W-1:0] scan_data,
  // Host pins
  php_bus_if.device bus
);
  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  localparam int NSIG = 4 + ADDR_W + DATA_W;
  logic [NSIG-1:0] raw;
  logic [NSIG-1:0] s1_q;
  logic [NSIG-1:0] s2_q;
  logic [NSIG-1:0] s3_q;
  logic [NSIG-1:0] st_q;
  assign raw = {bus.cs_n, bus.rd_ds_n, bus.wr_rw_n, bus.rst_n, bus.addr, bus.data_in};
  genvar gi;
  generate
    for (gi = 0; gi < NSIG; gi++) begin : g_sync
      always_ff @(posedge clk_sys) begin
        if (srst) begin
          s1_q[gi] <= 1'b1;
          s2_q[gi] <= 1'b1;
          s3_q[gi] <= 1'b1;
          st_q[gi] <= 1'b1;
        end else begin
          s1_q[gi] <= raw[gi];
          s2_q[gi] <= s1_q[gi];
          s3_q[gi] <= s2_q[gi];
          if (s2_q[gi] == s3_q[gi]) begin
            st_q[gi] <= s3_q[gi];
          end
        end
      end
    end
  endgenerate
  wire cs_n_s = st_q[NSIG-1];
  wire rd_ds_n_s = st_q[NSIG-2];
  wire wr_rw_n_s = st_q[NSIG-3];
  wire rst_n_s = st_q[NSIG-4];
  wire [ADDR_W-1:0] addr_s = st_q[DATA_W +: ADDR_W];
  wire [DATA_W-1:0] din_s = st_q[DATA_W-1:0];
  // ----------------------------------------
  // Access decode
  // ----------------------------------------
  logic wr_strb_q;
  logic ds_q;
  wire sel = !cs_n_s && rst_n_s;
  wire pair = (bus_mode == php_pkg::PHP_MODE_PAIR);
  wire wr_strb_hi = !wr_rw_n_s;
  wire ds_low = !rd_ds_n_s;
  wire pair_wr = pair && sel && wr_strb_q && wr_rw_n_s;
  wire dir_wr = !pair && sel && ds_low && !ds_q && !wr_rw_n_s;
  wire do_wr = pair_wr || dir_wr;
  wire pair_rd = pair && sel && ds_low;
  wire dir_rd = !pair && sel && ds_low && wr_rw_n_s;
  wire do_rd = pair_rd || dir_rd;
  // ----------------------------------------
  // Register file
  // ----------------------------------------
  logic [DATA_W-1:0] mem_q [0:(1<<ADDR_W)-1];
  logic [DATA_W-1:0] rdata_q;
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      wr_strb_q <= 1'b0;
      ds_q <= 1'b0;
    end else begin
      wr_strb_q <= sel && wr_strb_hi;
      ds_q <= sel && ds_low;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (do_wr) begin
      mem_q[addr_s] <= din_s;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rdata_q <= `PHP_REG_RST;
    end else begin
      rdata_q <= mem_q[addr_s];
    end
  end
  // ----------------------------------------
  // Data pins
  // ----------------------------------------
  wire live = !bus.cs_n && bus.rst_n;
  assign bus.data_dev_o = bus.scan_mode ? scan_data : rdata_q;
  assign bus.data_dev_oe = {DATA_W{bus.scan_mode || (live && do_rd)}};
endmodule

// >>> logic/php_host.sv
// Host end: drives register accesses onto the parallel port
`timescale 1ns/1ps
`include "php_defs.svh"
module php_host (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // Configuration
  input wire php_pkg::php_mode_type bus_mode,
  // User request
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_write,
  input wire logic [9:0] req_addr,
  input wire logic [7:0] req_wdata,
  output logic rsp_valid,
  output logic [7:0] rsp_rdata,
  // Pins
  php_bus_if.host bus
);
  php_pkg::php_hstate_type st_q;
  logic [3:0] cnt_q;
  logic wr_q;
  logic [9:0] addr_q;
  logic [7:0] wd_q;
  logic rv_q;
  logic [7:0] rd_q;
  wire pair = (bus_mode == php_pkg::PHP_MODE_PAIR);
  wire idle = (st_q == php_pkg::PHP_H_IDLE);
  wire strobe = (st_q == php_pkg::PHP_H_STROBE);
  wire busy = !idle;
  assign req_ready = idle;
  assign rsp_valid = rv_q;
  assign rsp_rdata = rd_q;
  assign bus.addr = addr_q;
  assign bus.rst_n = !srst;
  assign bus.cs_n = !busy;
  assign bus.rd_ds_n = pair ? !(strobe && !wr_q) : !strobe;
  assign bus.wr_rw_n = pair ? !(strobe && wr_q) : !(busy && wr_q);
  assign bus.data_host_o = wd_q;
  assign bus.data_host_oe = busy && wr_q;
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      st_q <= php_pkg::PHP_H_IDLE;
      cnt_q <= 4'h0;
      wr_q <= 1'b0;
      addr_q <= 10'h000;
      wd_q <= 8'h00;
      rv_q <= 1'b0;
      rd_q <= 8'h00;
    end else begin
      rv_q <= 1'b0;
      unique case (st_q)
        php_pkg::PHP_H_IDLE: begin
          if (req_valid) begin
            wr_q <= req_write;
            addr_q <= req_addr;
            wd_q <= req_wdata;
            cnt_q <= `PHP_HOST_SETUP;
            st_q <= php_pkg::PHP_H_SETUP;
          end
        end
        php_pkg::PHP_H_SETUP: begin
          cnt_q <= cnt_q - 4'h1;
          if (cnt_q == 4'h0) begin
            cnt_q <= `PHP_HOST_STROBE;
            st_q <= php_pkg::PHP_H_STROBE;
          end
        end
        php_pkg::PHP_H_STROBE: begin
          cnt_q <= cnt_q - 4'h1;
          if (cnt_q == 4'h0) begin
            rd_q <= bus.data_in;
            rv_q <= !wr_q;
            cnt_q <= `PHP_HOST_HOLD;
            st_q <= php_pkg::PHP_H_HOLD;
          end
        end
        php_pkg::PHP_H_HOLD: begin
          cnt_q <= cnt_q - 4'h1;
          if (cnt_q == 4'h0) begin
            st_q <= php_pkg::PHP_H_IDLE;
          end
        end
      endcase
    end
  end
endmodule

// >>> logic/php_pkg.sv
// Types of the parallel host register port
package php_pkg;
  typedef enum logic [0:0] {
    PHP_MODE_PAIR = 1'b0,
    PHP_MODE_DIR = 1'b1
  } php_mode_type;
  typedef enum logic [3:0] {
    PHP_H_IDLE = 4'b0001,
    PHP_H_SETUP = 4'b0010,
    PHP_H_STROBE = 4'b0100,
    PHP_H_HOLD = 4'b1000
  } php_hstate_type;
endpackage

// >>> tb/php_bus_monitor.sv
// Assertion checker on the host port pins
`timescale 1ns/1ps
module php_bus_monitor (
  // Clock and reset
  input logic clk_sys,
  input logic srst,
  // Pins
  input logic [9:0] addr,
  input logic cs_n,
  input logic rd_ds_n,
  input logic wr_rw_n,
  input logic rst_n,
  input logic data_host_oe,
  input logic [7:0] data_dev_oe,
  input logic scan_mode
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  property p_rel; (cs_n || !rst_n) && !scan_mode |-> data_dev_oe == 8'h00; endproperty
  a_rel: assert property (p_rel) else $error("Bus driven when released");
  property p_ign; cs_n |-> rd_ds_n && !data_host_oe; endproperty
  a_ign: assert property (p_ign) else $error("Strobe while deselected");
  property p_adr; !cs_n && $past(!cs_n) |-> $stable(addr); endproperty
  a_adr: assert property (p_adr) else $error("Address moved in access");
  property p_stb; $fell(rd_ds_n) |-> (!rd_ds_n && !cs_n) [*5] ##1 rd_ds_n; endproperty
  a_stb: assert property (p_stb) else $error("Strobe width wrong");
  property p_one; !(data_host_oe && (|data_dev_oe)); endproperty
  a_one: assert property (p_one) else $error("Both ends drive");
  property p_rdo; (|data_dev_oe) && !scan_mode |-> !cs_n && wr_rw_n; endproperty
  a_rdo: assert property (p_rdo) else $error("Drive outside read");
  property p_drv; $fell(rd_ds_n) && wr_rw_n |-> ##[1:5] (data_dev_oe == 8'hff); endproperty
  a_drv: assert property (p_drv) else $error("Read data not driven");
  property p_scn; scan_mode |-> data_dev_oe == 8'hff; endproperty
  a_scn: assert property (p_scn) else $error("Scan not driving");
endmodule

// >>> tb/tb.sv
// Bench joining host and device ends
`timescale 1ns/1ps
module tb;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  php_pkg::php_mode_type bus_mode = php_pkg::PHP_MODE_PAIR;
  logic [7:0] scan_data = 8'h00;
  logic req_valid = 1'b0;
  logic req_ready;
  logic req_write = 1'b0;
  logic [9:0] req_addr = 10'h000;
  logic [7:0] req_wdata = 8'h00;
  logic rsp_valid;
  logic [7:0] rsp_rdata;
  int err_count = 0;
  int comparisons = 0;
  int cycles = 0;
  logic [9:0] addr_tab [3] = '{10'h001, 10'h200, 10'h3ff};
  logic [7:0] data_tab [3] = '{8'h01, 8'h80, 8'h5a};
  php_bus_if bus ();
  php_device u_php_device (.clk_sys(clk_sys), .srst(srst), .bus_mode(bus_mode),
    .scan_data(scan_data), .bus(bus.device));
  php_host u_php_host (.clk_sys(clk_sys), .srst(srst), .bus_mode(bus_mode),
    .req_valid(req_valid), .req_ready(req_ready), .req_write(req_write),
    .req_addr(req_addr), .req_wdata(req_wdata), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata), .bus(bus.host));
  php_bus_monitor u_php_bus_monitor (.clk_sys(clk_sys), .srst(srst), .addr(bus.addr),
    .cs_n(bus.cs_n), .rd_ds_n(bus.rd_ds_n), .wr_rw_n(bus.wr_rw_n), .rst_n(bus.rst_n),
    .data_host_oe(bus.data_host_oe), .data_dev_oe(bus.data_dev_oe),
    .scan_mode(bus.scan_mode));
  initial begin
    forever #12.5 clk_sys = ~clk_sys;
  end
  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      test_done();
    end
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic access(input logic wr, input logic [9:0] a, input logic [7:0] d,
    output logic [7:0] q);
    @(negedge clk_sys);
    while (req_ready !== 1'b1) @(negedge clk_sys);
    req_valid = 1'b1;
    req_write = wr;
    req_addr = a;
    req_wdata = d;
    @(negedge clk_sys);
    req_valid = 1'b0;
    q = 8'h00;
    if (!wr) begin
      while (rsp_valid !== 1'b1) @(negedge clk_sys);
      q = rsp_rdata;
    end
  endtask
  task automatic test_idle();
    @(negedge clk_sys);
    chk(bus.data_dev_oe, 8'h00);
    $display("Idle test done");
  endtask
  task automatic test_mode(input php_pkg::php_mode_type m, input logic [7:0] x);
    logic [7:0] q;
    @(negedge clk_sys);
    while (req_ready !== 1'b1) @(negedge clk_sys);
    repeat (8) @(negedge clk_sys);
    bus_mode = m;
    for (int i = 0; i < 3; i++) access(1'b1, addr_tab[i], data_tab[i] ^ x, q);
    for (int i = 0; i < 3; i++) begin
      access(1'b0, addr_tab[i], 8'h00, q);
      chk(q, data_tab[i] ^ x);
    end
    $display("Mode test done");
  endtask
  task automatic test_scan();
    @(negedge clk_sys);
    bus.scan_mode = 1'b1;
    scan_data = 8'ha5;
    @(negedge clk_sys);
    chk(bus.data_in, 8'ha5);
    bus.scan_mode = 1'b0;
    @(negedge clk_sys);
    chk(bus.data_dev_oe, 8'h00);
    $display("Scan test done");
  endtask
  initial begin
    bus.scan_mode = 1'b0;
    repeat (16) @(posedge clk_sys);
    @(negedge clk_sys);
    srst = 1'b0;
    test_idle();
    test_mode(php_pkg::PHP_MODE_PAIR, 8'h00);
    test_mode(php_pkg::PHP_MODE_DIR, 8'hff);
    test_scan();
    test_done();
  end
endmodule
